// file: design/tlbtp_pkg.sv
// constants for the translation buffer test port: field positions, geometry and reset values
package tlbtp_pkg;
  // geometry
  localparam int SETS     = 8;
  localparam int WAYS     = 4;
  localparam int SET_BITS = 3;
  localparam int WAY_BITS = 2;
  localparam int TAG_BITS = 17;
  localparam int PA_BITS  = 20;
  localparam int LRU_BITS = 3;
  // command register fields
  localparam int CMD_LA_LSB = 12;
  localparam int CMD_TAG_LSB = 15;
  localparam int CMD_V      = 11;
  localparam int CMD_D      = 10;
  localparam int CMD_DN     = 9;
  localparam int CMD_U      = 8;
  localparam int CMD_UN     = 7;
  localparam int CMD_W      = 6;
  localparam int CMD_WN     = 5;
  localparam int CMD_OP     = 0;
  localparam logic OP_WRITE  = 1'b0;
  localparam logic OP_LOOKUP = 1'b1;
  // data register fields
  localparam int DAT_PA_LSB  = 12;
  localparam int DAT_PCD     = 11;
  localparam int DAT_PWT     = 10;
  localparam int DAT_LRU_LSB = 7;
  localparam int DAT_HIT     = 4;
  localparam int DAT_PTR_LSB = 2;
  localparam int DAT_ENT_LSB = 10;
  // writable bits of each register, the rest read as zero
  localparam logic [31:0] CMD_MASK  = 32'hFFFF_FFE1;
  localparam logic [31:0] DATA_MASK = 32'hFFFF_FF9C;
  // register select encoding of the move port
  localparam logic SEL_CMD  = 1'b0;
  localparam logic SEL_DATA = 1'b1;
  // reset values
  localparam logic [31:0] CMD_RST  = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [2:0]  LRU_RST  = 3'h0;
endpackage : tlbtp_pkg

// file: design/tlbtp_top.sv
// translation buffer test port: command and data test registers over a 4-way, 32-entry buffer
// Functional notes
// RL1 - writing the command register starts a test write or test lookup
// RL2 - command: linear address 31:12, valid 11, protection pairs 10:5, operation bit 0
// RL3 - low three address bits pick one of eight sets; upper 17 form the tag
// RL4 - operation bit 0 means test write, 1 means test lookup
// RL5 - on write, pair 01 stores 0, 10 stores 1, others undefined
// RL6 - on lookup, pair 00 misses, 01 matches 0, 10 matches 1, 11 matches any
// RL7 - data: physical address 31:12, cache disable 11, write through 10, LRU 9:7, pointer 3:2
// RL8 - on write, data bit 4 picks pointer: 0 pseudo-LRU, 1 data bits 3:2
// RL9 - selected pointer chooses which of four entries in the set is written
// RL10 - every write makes the written entry most recently used
// RL11 - software loads the data register before the command register for writes
// RL12 - LRU field of the data register is ignored on a test write
// RL13 - after lookup, data bit 4 is 1 on hit, 0 on miss
// RL14 - after hit, bits 3:2 give the entry, top 22 bits its address and attributes
// RL15 - after hit, bits 9:7 hold the set LRU bits before this lookup updated them
// RL16 - after a miss, bits other than the hit flag are undefined
// RL17 - a hit makes the hit entry most recently used
// RL18 - duplicate address in one set never reports a hit; software avoids duplicates
// RL19 - test operations work with paging enabled
// RL20 - registers are reached only by register move transfers
// RL21 - four ways, 32 entries, eight sets of four
// RL22 - one three-bit pseudo-LRU state per set, cache replacement algorithm
// RL23 - hit needs tag match, valid and all protection pair conditions
`timescale 1ns/10ps
module tlbtp_top (
  input  wire logic        mclk,        // core clock, 125 MHz
  input  wire logic        sys_rst,     // asynchronous reset, active high
  input  wire logic        treg_wr,     // move into a test register, one-cycle strobe
  input  wire logic        treg_sel,    // 0 command register, 1 data register
  input  wire logic [31:0] treg_wdata,  // value moved from a general register
  output logic      [31:0] treg_rdata,  // value moved to a general register
  output logic             test_done    // pulse, one cycle after a command write
);

  // storage per set and way
  logic [tlbtp_pkg::TAG_BITS-1:0] tag_reg   [tlbtp_pkg::SETS][tlbtp_pkg::WAYS];
  logic [tlbtp_pkg::PA_BITS+1:0]  entry_reg [tlbtp_pkg::SETS][tlbtp_pkg::WAYS]; // pa, cache disable, write through
  logic [2:0]                     prot_reg  [tlbtp_pkg::SETS][tlbtp_pkg::WAYS]; // dirty, user, write
  logic                           valid_reg [tlbtp_pkg::SETS][tlbtp_pkg::WAYS];
  logic [tlbtp_pkg::LRU_BITS-1:0] lru_reg   [tlbtp_pkg::SETS];
  logic [31:0]                    tlb_test_command_reg;
  logic [31:0]                    tlb_test_data_reg;
  logic [31:0]                    tlb_test_data_next;

  // lookup pair condition, true bit then complement bit
  function automatic logic pair_ok(input logic t, input logic c, input logic s);
    case ({t, c})
      2'b00:   pair_ok = 1'b0;
      2'b01:   pair_ok = ~s;
      2'b10:   pair_ok = s;
      default: pair_ok = 1'b1;
    endcase
  endfunction : pair_ok

  // pseudo-LRU victim from the tree bits alone
  function automatic logic [1:0] plru_pick(input logic [2:0] l);
    plru_pick = l[0] ? {1'b1, l[2]} : {1'b0, l[1]};
  endfunction : plru_pick

  // victim: first invalid way, else the tree choice
  function automatic logic [1:0] plru_victim(input logic [2:0] l, input logic [3:0] v);
    if (!v[0]) plru_victim = 2'h0;
    else if (!v[1]) plru_victim = 2'h1;
    else if (!v[2]) plru_victim = 2'h2;
    else if (!v[3]) plru_victim = 2'h3;
    else plru_victim = plru_pick(l);
  endfunction : plru_victim

  // tree bits after touching a way, so the touched way is most recently used
  function automatic logic [2:0] plru_touch(input logic [2:0] l, input logic [1:0] w);
    logic [2:0] r;
    r = l;
    r[0] = ~w[1];
    if (w[1]) r[2] = ~w[0];
    else r[1] = ~w[0];
    plru_touch = r;
  endfunction : plru_touch

  // command decode, taken straight from the moved value
  wire cmd_wr  = treg_wr && (treg_sel == tlbtp_pkg::SEL_CMD);                       // RL1 RL20
  wire data_wr = treg_wr && (treg_sel == tlbtp_pkg::SEL_DATA);                      // RL20
  wire do_write = cmd_wr && (treg_wdata[tlbtp_pkg::CMD_OP] == tlbtp_pkg::OP_WRITE);  // RL4
  wire do_look  = cmd_wr && (treg_wdata[tlbtp_pkg::CMD_OP] == tlbtp_pkg::OP_LOOKUP); // RL4
  wire [tlbtp_pkg::SET_BITS-1:0] set_idx = treg_wdata[tlbtp_pkg::CMD_LA_LSB +: tlbtp_pkg::SET_BITS]; // RL3
  wire [tlbtp_pkg::TAG_BITS-1:0] la_tag  = treg_wdata[tlbtp_pkg::CMD_TAG_LSB +: tlbtp_pkg::TAG_BITS]; // RL3
  // protection bits to store: the true bit of each pair
  wire [2:0] prot_store = {treg_wdata[tlbtp_pkg::CMD_D], treg_wdata[tlbtp_pkg::CMD_U],
                           treg_wdata[tlbtp_pkg::CMD_W]}; // RL5

  // per-way match for the addressed set
  logic [3:0] way_match;
  logic [3:0] set_valid;
  genvar gw;
  generate
    for (gw = 0; gw < tlbtp_pkg::WAYS; gw++) begin : g_way
      assign set_valid[gw] = valid_reg[set_idx][gw];
      assign way_match[gw] = valid_reg[set_idx][gw] && treg_wdata[tlbtp_pkg::CMD_V]
                           && (tag_reg[set_idx][gw] == la_tag)
                           && pair_ok(treg_wdata[tlbtp_pkg::CMD_D], treg_wdata[tlbtp_pkg::CMD_DN],
                                      prot_reg[set_idx][gw][2])
                           && pair_ok(treg_wdata[tlbtp_pkg::CMD_U], treg_wdata[tlbtp_pkg::CMD_UN],
                                      prot_reg[set_idx][gw][1])
                           && pair_ok(treg_wdata[tlbtp_pkg::CMD_W], treg_wdata[tlbtp_pkg::CMD_WN],
                                      prot_reg[set_idx][gw][0]); // RL6 RL23
    end
  endgenerate

  // exactly one matching way counts as a hit; duplicates miss
  wire single_hit = (way_match != 4'h0) && ((way_match & (way_match - 4'h1)) == 4'h0); // RL18
  wire [1:0] hit_way = {way_match[3] | way_match[2], way_match[3] | way_match[1]};
  wire [tlbtp_pkg::LRU_BITS-1:0] set_lru = lru_reg[set_idx];
  wire [tlbtp_pkg::PA_BITS+1:0] hit_entry = entry_reg[set_idx][hit_way];

  // replacement pointer for a test write
  wire [1:0] wr_way = tlb_test_data_reg[tlbtp_pkg::DAT_HIT]
                    ? tlb_test_data_reg[tlbtp_pkg::DAT_PTR_LSB +: 2]
                    : plru_victim(set_lru, set_valid); // RL8 RL9
  // lru state after the operation, touching the written or hit way
  wire [2:0] lru_after = plru_touch(set_lru, do_write ? wr_way : hit_way); // RL10 RL17
  wire       lru_upd   = do_write || (do_look && single_hit);               // RL10 RL17

  // data register next value: software load, lookup result, or hold
  always_comb begin
    tlb_test_data_next = tlb_test_data_reg;
    if (data_wr) begin
      tlb_test_data_next = treg_wdata & tlbtp_pkg::DATA_MASK; // RL7
    end else if (do_look && single_hit) begin
      tlb_test_data_next = 32'h0000_0000;
      tlb_test_data_next[31:tlbtp_pkg::DAT_ENT_LSB] = hit_entry;                        // RL14
      tlb_test_data_next[tlbtp_pkg::DAT_LRU_LSB +: tlbtp_pkg::LRU_BITS] = set_lru;      // RL15
      tlb_test_data_next[tlbtp_pkg::DAT_HIT] = 1'b1;                                    // RL13
      tlb_test_data_next[tlbtp_pkg::DAT_PTR_LSB +: 2] = hit_way;                        // RL14
    end else if (do_look) begin
      tlb_test_data_next[tlbtp_pkg::DAT_HIT] = 1'b0; // RL13 RL16
    end
  end

  // test registers and completion pulse
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tlb_test_command_reg <= tlbtp_pkg::CMD_RST;
      tlb_test_data_reg    <= tlbtp_pkg::DATA_RST;
      test_done            <= 1'b0;
    end else begin
      if (cmd_wr) tlb_test_command_reg <= treg_wdata & tlbtp_pkg::CMD_MASK; // RL2
      tlb_test_data_reg <= tlb_test_data_next;
      test_done         <= cmd_wr; // RL1
    end
  end

  // buffer arrays; paging state does not gate either operation
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int s = 0; s < tlbtp_pkg::SETS; s++) begin
        lru_reg[s] <= tlbtp_pkg::LRU_RST; // RL22
        for (int w = 0; w < tlbtp_pkg::WAYS; w++) begin
          valid_reg[s][w] <= 1'b0;
          tag_reg[s][w]   <= '0;
          entry_reg[s][w] <= '0;
          prot_reg[s][w]  <= 3'h0;
        end
      end
    end else begin
      if (do_write) begin // RL19 RL21
        valid_reg[set_idx][wr_way] <= treg_wdata[tlbtp_pkg::CMD_V];
        tag_reg[set_idx][wr_way]   <= la_tag;                                                    // RL3 RL9
        entry_reg[set_idx][wr_way] <= tlb_test_data_reg[31:tlbtp_pkg::DAT_ENT_LSB];             // RL7 RL12
        prot_reg[set_idx][wr_way]  <= prot_store;                                                // RL5
      end
      if (lru_upd) lru_reg[set_idx] <= lru_after; // RL10 RL17 RL22
    end
  end

  // move-out mux between the two test registers
  assign treg_rdata = (treg_sel == tlbtp_pkg::SEL_DATA) ? tlb_test_data_reg : tlb_test_command_reg; // RL20

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  done_pulse_a: assert property (cmd_wr |=> test_done ##1 (test_done == $past(cmd_wr))) // RL1
    else $error("command write did not pulse done once");
  hit_flag_a: assert property (do_look |=> tlb_test_data_reg[tlbtp_pkg::DAT_HIT] == $past(single_hit)) // RL13
    else $error("lookup hit flag wrong");
  hit_entry_a: assert property (do_look && single_hit |=>
      tlb_test_data_reg[31:tlbtp_pkg::DAT_ENT_LSB] == $past(hit_entry)
      && tlb_test_data_reg[3:2] == $past(hit_way)) // RL14
    else $error("hit entry or location wrong");
  pre_lru_a: assert property (do_look && single_hit |=>
      tlb_test_data_reg[9:7] == $past(set_lru)) // RL15
    else $error("reported lru not the pre-update value");
  write_mru_a: assert property (do_write |=> plru_pick(lru_reg[$past(set_idx)]) != $past(wr_way)) // RL10
    else $error("written way still chosen as victim");
  hit_mru_a: assert property (do_look && single_hit |=>
      plru_pick(lru_reg[$past(set_idx)]) != $past(hit_way)) // RL17
    else $error("hit way still chosen as victim");
  miss_lru_a: assert property (do_look && !single_hit |=>
      lru_reg[$past(set_idx)] == $past(set_lru)) // RL17
    else $error("miss changed lru state");
  dup_miss_a: assert property (do_look && ($countones(way_match) > 1) |=>
      !tlb_test_data_reg[tlbtp_pkg::DAT_HIT]) // RL18
    else $error("duplicate match reported a hit");
  ptr_write_a: assert property (do_write && tlb_test_data_reg[tlbtp_pkg::DAT_HIT] |=>
      tag_reg[$past(set_idx)][$past(tlb_test_data_reg[3:2])] == $past(la_tag)) // RL8
    else $error("explicit pointer not used on write");
  rsvd_zero_a: assert property ((tlb_test_data_reg & ~tlbtp_pkg::DATA_MASK) == 32'h0000_0000) // RL7
    else $error("reserved data bits set");

  // command register takes the masked moved value
  cmd_load_a: assert property (cmd_wr |=> // RL2
      tlb_test_command_reg == ($past(treg_wdata) & tlbtp_pkg::CMD_MASK))
    else $error("command register load wrong");

  // command register holds between command moves
  cmd_hold_a: assert property (!cmd_wr |=> $stable(tlb_test_command_reg)) // RL2
    else $error("command register changed without a move");

  // command register never shows reserved bits
  cmd_rsvd_a: assert property ((tlb_test_command_reg & ~tlbtp_pkg::CMD_MASK) == 32'h0000_0000) // RL2
    else $error("reserved command bits set");

  // data register takes the masked moved value
  data_load_a: assert property (data_wr |=> // RL7
      tlb_test_data_reg == ($past(treg_wdata) & tlbtp_pkg::DATA_MASK))
    else $error("data register load wrong");

  // a test write leaves the data register alone, lru field included
  write_keeps_data_a: assert property (do_write |=> $stable(tlb_test_data_reg)) // RL12
    else $error("test write changed the data register");

  // nothing but a move or a lookup touches the data register
  idle_data_a: assert property (!treg_wr |=> $stable(tlb_test_data_reg)) // RL20
    else $error("data register changed while idle");

  // a miss only clears the hit flag
  miss_keep_a: assert property (do_look && !single_hit |=> // RL16
      tlb_test_data_reg[31:5] == $past(tlb_test_data_reg[31:5]))
    else $error("miss disturbed the data register");

  // unused result bits of a hit read as zero
  hit_low_zero_a: assert property (do_look && single_hit |=> // RL14
      tlb_test_data_reg[6:5] == 2'h0 && tlb_test_data_reg[1:0] == 2'h0)
    else $error("hit result has stray bits");

  // written way gets the linear address tag
  write_tag_a: assert property (do_write |=> // RL3 RL9
      tag_reg[$past(set_idx)][$past(wr_way)] == $past(la_tag))
    else $error("written tag wrong");

  // written way gets address and attributes from the data register
  write_entry_a: assert property (do_write |=> // RL7 RL12
      entry_reg[$past(set_idx)][$past(wr_way)] == $past(tlb_test_data_reg[31:10]))
    else $error("written entry wrong");

  // written way stores the true bit of each pair
  write_prot_a: assert property (do_write |=> // RL5
      prot_reg[$past(set_idx)][$past(wr_way)] == $past(prot_store))
    else $error("written protection bits wrong");

  // written way stores the valid bit of the command
  write_valid_a: assert property (do_write |=> // RL23
      valid_reg[$past(set_idx)][$past(wr_way)] == $past(treg_wdata[tlbtp_pkg::CMD_V]))
    else $error("written valid bit wrong");

  // full set with pointer select clear uses the tree victim
  plru_ptr_a: assert property (do_write && !tlb_test_data_reg[tlbtp_pkg::DAT_HIT] && // RL8
      (set_valid == 4'hF) |-> wr_way == plru_pick(set_lru))
    else $error("pseudo-lru pointer not used");

  // lookups never store a tag
  look_no_store_a: assert property (do_look |=> // RL4
      tag_reg[$past(set_idx)][$past(hit_way)] == $past(tag_reg[set_idx][hit_way]))
    else $error("lookup changed a tag");

  // a hit needs a valid entry and a valid command
  hit_valid_a: assert property (do_look && single_hit |-> // RL23
      valid_reg[set_idx][hit_way] && treg_wdata[tlbtp_pkg::CMD_V])
    else $error("hit on an invalid entry");

  // duplicate matches leave the lru state alone
  dup_no_lru_a: assert property (do_look && ($countones(way_match) > 1) |=> // RL18
      lru_reg[$past(set_idx)] == $past(set_lru))
    else $error("duplicate match changed lru state");

  // lru state moves only on a command
  lru_idle_a: assert property (!cmd_wr |=> // RL22
      lru_reg[$past(set_idx)] == $past(set_lru))
    else $error("lru state changed without a command");

  // done pulses only after a command move
  done_only_a: assert property (!cmd_wr |=> !test_done) // RL1
    else $error("done without a command");

  // command register is what a move out reads when selected
  rdata_cmd_a: assert property (treg_sel == tlbtp_pkg::SEL_CMD |-> // RL20
      treg_rdata == tlb_test_command_reg)
    else $error("move out shows the wrong register");
endmodule : tlbtp_top

// file: verification/tlb_test_port_tb.sv
// self-checking bench for the translation buffer test port
`timescale 1ns/10ps
module tlb_test_port_tb;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] msk;
  } tlbtp_note_t;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        mclk;
  logic        sys_rst;
  logic        treg_wr;
  logic        treg_sel;
  logic [31:0] treg_wdata;
  logic [31:0] treg_rdata;
  logic        test_done;
  logic        rd_ev;
  int          err_total;
  int          checked;
  tlbtp_note_t notes[$];
  logic [16:0] m_tag[8][4];
  logic        m_v[8][4];
  logic [2:0]  m_prot[8][4];
  logic [21:0] m_pa[8][4];
  logic [2:0]  m_lru[8];
  logic [19:0] pool[6];
  logic [31:0] last_cmd;

  tlbtp_top dut (.mclk(mclk), .sys_rst(sys_rst), .treg_wr(treg_wr), .treg_sel(treg_sel),
                 .treg_wdata(treg_wdata), .treg_rdata(treg_rdata), .test_done(test_done));

  // core clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic end_of_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // watcher: oldest note against each result
  always @(negedge mclk) begin
    if (test_done === 1'b1 || rd_ev) begin
      checked++;
      if (notes.size() == 0 || (treg_rdata & notes[0].msk) !== (notes[0].val & notes[0].msk)) begin
        $display("ERROR t=%0t got=%h exp=%h", $time, treg_rdata, notes.size() ? notes[0].val : 32'h0);
        err_total++;
      end
      if (notes.size() > 0) begin
        void'(notes.pop_front());
      end
    end
  end

  // move into a register, then park on the data register
  task automatic mov_in(input logic sel, input logic [31:0] v);
    @(posedge mclk);
    treg_wr    <= 1'b1;
    treg_sel   <= sel;
    treg_wdata <= v;
    @(posedge mclk);
    treg_wr    <= 1'b0;
    treg_sel   <= 1'b1;
  endtask : mov_in

  // move out of a register with its expected value
  task automatic mov_out(input logic sel, input logic [31:0] e);
    notes.push_back('{e, ALL});
    @(posedge mclk);
    treg_sel <= sel;
    rd_ev    <= 1'b1;
    @(posedge mclk);
    rd_ev    <= 1'b0;
    treg_sel <= 1'b1;
  endtask : mov_out

  // command move, bounded wait for its completion
  task automatic command(input logic [31:0] c, input tlbtp_note_t n);
    notes.push_back(n);
    last_cmd = c;
    mov_in(tlbtp_pkg::SEL_CMD, c);
    for (int i = 0; i < 4 && notes.size() > 0; i++) @(posedge mclk);
    if (notes.size() > 0) begin
      $display("ERROR t=%0t no completion got=%h exp=%h", $time, 1'b0, 1'b1);
      err_total++;
      end_of_test();
    end
  endtask : command

  // reference pseudo-LRU victim and update
  function automatic logic [1:0] victim(input logic [2:0] s);
    for (int w = 0; w < 4; w++) if (!m_v[s][w]) return w[1:0];
    return m_lru[s][0] ? {1'b1, m_lru[s][2]} : {1'b0, m_lru[s][1]};
  endfunction : victim

  function automatic void touch(input logic [2:0] s, input logic [1:0] w);
    m_lru[s][0] = ~w[1];
    if (w[1]) m_lru[s][2] = ~w[0];
    else m_lru[s][1] = ~w[0];
  endfunction : touch

  function automatic logic pair_ok(input logic [1:0] pr, input logic b);
    return (pr[1] & (pr[0] | b)) | (pr[0] & ~b);
  endfunction : pair_ok

  // test write: data first, then command
  task automatic test_write;
    logic [19:0] la;
    logic [31:0] d;
    logic [2:0]  p;
    logic        v;
    logic [1:0]  w;
    la = pool[$urandom % 6];
    d  = $urandom;
    p  = 3'($urandom);
    v  = ($urandom % 8) != 0;
    w  = d[4] ? d[3:2] : victim(la[2:0]);
    mov_in(tlbtp_pkg::SEL_DATA, d);
    {m_tag[la[2:0]][w], m_v[la[2:0]][w], m_prot[la[2:0]][w], m_pa[la[2:0]][w]} = {la[19:3], v, p, d[31:10]};
    touch(la[2:0], w);
    command({la, v, p[2], ~p[2], p[1], ~p[1], p[0], ~p[0], 5'h00}, '{d & tlbtp_pkg::DATA_MASK, ALL});
  endtask : test_write

  // test lookup against the reference buffer
  task automatic test_lookup;
    logic [19:0] la;
    logic [5:0]  pp;
    logic        v;
    logic [2:0]  s;
    int          n;
    logic [1:0]  hw;
    tlbtp_note_t e;
    la = pool[$urandom % 6];
    s  = la[2:0];
    v  = ($urandom % 8) != 0;
    for (int b = 0; b < 6; b += 2) pp[b+:2] = ($urandom % 2) ? 2'b11 : 2'($urandom);
    n  = 0;
    hw = 2'h0;
    for (int w = 0; w < 4; w++) begin
      if (m_v[s][w] && v && m_tag[s][w] == la[19:3] && pair_ok(pp[5:4], m_prot[s][w][2]) &&
          pair_ok(pp[3:2], m_prot[s][w][1]) && pair_ok(pp[1:0], m_prot[s][w][0])) begin
        n++;
        hw = w[1:0];
      end
    end
    e = '{32'h0, 32'h10};
    if (n == 1) begin
      e = '{{m_pa[s][hw], m_lru[s], 2'h0, 1'b1, hw, 2'h0}, ALL};
      touch(s, hw);
    end
    command({la, v, pp, 5'h01}, e);
  endtask : test_lookup

  // main sequence
  initial begin
    sys_rst    = 1'b1;
    treg_wr    = 1'b0;
    treg_sel   = 1'b1;
    treg_wdata = 32'h0;
    rd_ev      = 1'b0;
    err_total  = 0;
    checked    = 0;
    void'($urandom(32'hD5F8));
    for (int i = 0; i < 6; i++) pool[i] = {17'($urandom), 3'(i % 2)};
    foreach (m_v[s, w]) {m_tag[s][w], m_v[s][w], m_prot[s][w], m_pa[s][w]} = '0;
    foreach (m_lru[s]) m_lru[s] = tlbtp_pkg::LRU_RST;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    mov_out(tlbtp_pkg::SEL_CMD, tlbtp_pkg::CMD_RST);
    mov_out(tlbtp_pkg::SEL_DATA, tlbtp_pkg::DATA_RST);
    mov_in(tlbtp_pkg::SEL_DATA, ALL);
    mov_out(tlbtp_pkg::SEL_DATA, tlbtp_pkg::DATA_MASK);
    for (int i = 0; i < 400; i++) begin
      if ($urandom % 2) test_write();
      else test_lookup();
    end
    mov_out(tlbtp_pkg::SEL_CMD, last_cmd & tlbtp_pkg::CMD_MASK);
    end_of_test();
  end
endmodule : tlb_test_port_tb
